//--- src/rgmii_pkg.sv
// Shared constants, types and decoders for both ends of the reduced gigabit link.
package rgmii_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  // The link clocks are scaled down to the 10 MHz reference, keeping the
  // 125 : 25 : 2.5 ratio of the three speeds.
  localparam int REF_PERIOD_NS = 100;
  localparam int LINK_PERIOD_1000_NS = 800;
  localparam int LINK_PERIOD_100_NS = 4000;
  localparam int LINK_PERIOD_10_NS = 40000;
  localparam int HALF_1000_CYC = LINK_PERIOD_1000_NS / (2 * REF_PERIOD_NS);
  localparam int HALF_100_CYC = LINK_PERIOD_100_NS / (2 * REF_PERIOD_NS);
  localparam int HALF_10_CYC = LINK_PERIOD_10_NS / (2 * REF_PERIOD_NS);

  // ------------------------------------------------------------------
  // Buffering and pin layout
  // ------------------------------------------------------------------
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int PIN_CLK_BIT = 5;
  localparam int PIN_CTL_BIT = 4;
  localparam int PIN_W = 6;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [3:0] NIB_IDLE = 4'h0;

  typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} link_speed_e;

  // ------------------------------------------------------------------
  // Decoders
  // ------------------------------------------------------------------
  function automatic logic [7:0] half_cycles(input link_speed_e speed);
    case (speed)
      SPEED_1000: half_cycles = 8'(HALF_1000_CYC);
      SPEED_100: half_cycles = 8'(HALF_100_CYC);
      default: half_cycles = 8'(HALF_10_CYC);
    endcase
  endfunction : half_cycles

  function automatic logic is_ddr(input link_speed_e speed);
    is_ddr = (speed == SPEED_1000);
  endfunction : is_ddr

endpackage : rgmii_pkg

//--- src/rgmii_if.sv
// Pin bundle between the media side device and the host controller.
`timescale 1ns/1ps
interface rgmii_if;
  logic tx_clk;
  logic tx_ctl;
  logic [3:0] txd;
  logic rx_clk;
  logic rx_ctl;
  logic [3:0] rxd;

  modport phy (
    input tx_clk,
    input tx_ctl,
    input txd,
    output rx_clk,
    output rx_ctl,
    output rxd
  );

  modport mac (
    output tx_clk,
    output tx_ctl,
    output txd,
    input rx_clk,
    input rx_ctl,
    input rxd
  );
endinterface : rgmii_if

//--- src/stream_fifo.sv
// Valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module stream_fifo
  import rgmii_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // One spare pointer bit tells full from empty.
  assign in_ready = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
    end
  end
endmodule : stream_fifo

//--- src/rgmii_phy_end.sv
// Media side end: link lane sender, lane receiver and the device top.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Lane sender: makes the lane clock by division and drives control/data.
// ------------------------------------------------------------------
module link_sender
  import rgmii_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input link_speed_e speed,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_err,
  output logic lclk,
  output logic ctl,
  output logic [3:0] dat
);
  logic [7:0] half;
  logic [7:0] cnt_r;
  logic lclk_r;
  logic ctl_r;
  logic [3:0] dat_r;
  logic [7:0] cur_r;
  logic cur_v_r;
  logic cur_err_r;
  logic nib_hi_r;
  logic mid;
  logic rise_mid;
  logic fall_mid;
  logic take;

  assign half = half_cycles(speed);
  // Pins change mid-way through each half period, so the far end's
  // three-stage sampling sees them settled on both sides of each edge.
  assign mid = (cnt_r == {1'b0, half[7:1]});
  assign rise_mid = mid && !lclk_r;
  assign fall_mid = mid && lclk_r;
  assign in_ready = rise_mid && (is_ddr(speed) || !nib_hi_r);
  assign take = in_ready && in_valid;
  assign lclk = lclk_r;
  assign ctl = ctl_r;
  assign dat = dat_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= CNT_RESET;
      lclk_r <= 1'b0;
    end else if (cnt_r >= half - 8'h01) begin
      cnt_r <= CNT_RESET;
      lclk_r <= !lclk_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur_r <= 8'h00;
      cur_v_r <= 1'b0;
      cur_err_r <= 1'b0;
    end else if (take) begin
      cur_r <= in_data;
      cur_v_r <= 1'b1;
      cur_err_r <= in_err;
    end else if (in_ready) begin
      cur_v_r <= 1'b0;
      cur_err_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nib_hi_r <= 1'b0;
    end else if (rise_mid && !is_ddr(speed)) begin
      nib_hi_r <= take;
    end else if (is_ddr(speed)) begin
      nib_hi_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= 1'b0;
    end else if (take) begin
      ctl_r <= 1'b1;
    end else if (in_ready) begin
      ctl_r <= 1'b0;
    end else if (fall_mid) begin
      ctl_r <= cur_v_r ^ cur_err_r;
    end else if (rise_mid) begin
      ctl_r <= cur_v_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dat_r <= NIB_IDLE;
    end else if (take) begin
      dat_r <= in_data[3:0];
    end else if (in_ready) begin
      dat_r <= NIB_IDLE;
    end else if (rise_mid && nib_hi_r) begin
      dat_r <= cur_r[7:4];
    end else if (fall_mid && is_ddr(speed)) begin
      dat_r <= cur_r[7:4];
    end
  end
endmodule : link_sender

// ------------------------------------------------------------------
// Lane receiver: samples a foreign lane clock and rebuilds bytes.
// ------------------------------------------------------------------
module link_receiver
  import rgmii_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input link_speed_e speed,
  input wire logic lclk,
  input wire logic ctl,
  input wire logic [3:0] dat,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_err
);
  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;
  logic lvl_r;
  logic rise;
  logic fall;
  logic ctl_rise_r;
  logic [3:0] lo_r;
  logic have_lo_r;
  logic pend_r;
  logic err_acc_r;
  logic edge_err;
  logic emit;

  // A lane clock change counts once stages two and three agree.
  assign rise = (s2_r[PIN_CLK_BIT] == s3_r[PIN_CLK_BIT]) && s3_r[PIN_CLK_BIT] && !lvl_r;
  assign fall = (s2_r[PIN_CLK_BIT] == s3_r[PIN_CLK_BIT]) && !s3_r[PIN_CLK_BIT] && lvl_r;
  assign edge_err = ctl_rise_r ^ s3_r[PIN_CTL_BIT];
  assign emit = fall && (is_ddr(speed) ? ctl_rise_r : pend_r);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= {lclk, ctl, dat};
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (rise || fall) begin
        lvl_r <= s3_r[PIN_CLK_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_rise_r <= 1'b0;
      lo_r <= NIB_IDLE;
      have_lo_r <= 1'b0;
      pend_r <= 1'b0;
      out_data <= 8'h00;
    end else if (rise) begin
      ctl_rise_r <= s3_r[PIN_CTL_BIT];
      if (is_ddr(speed) || !have_lo_r || !s3_r[PIN_CTL_BIT]) begin
        lo_r <= s3_r[3:0];
        have_lo_r <= s3_r[PIN_CTL_BIT] && !is_ddr(speed);
        pend_r <= 1'b0;
      end else begin
        out_data <= {s3_r[3:0], lo_r};
        have_lo_r <= 1'b0;
        pend_r <= 1'b1;
      end
    end else if (fall && is_ddr(speed)) begin
      out_data <= {s3_r[3:0], lo_r};
    end
  end

  // In slow modes a byte spans two lane periods, so errors accumulate.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      err_acc_r <= 1'b0;
    end else if (emit || (rise && !s3_r[PIN_CTL_BIT])) begin
      err_acc_r <= 1'b0;
    end else if (fall && ctl_rise_r) begin
      err_acc_r <= err_acc_r | edge_err;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_err <= 1'b0;
    end else begin
      out_valid <= emit;
      out_err <= emit && (edge_err || (!is_ddr(speed) && err_acc_r));
    end
  end
endmodule : link_receiver

// ------------------------------------------------------------------
// Device top: receive stream out to the host, transmit stream in.
// ------------------------------------------------------------------
module rgmii_phy_end
  import rgmii_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input link_speed_e speed,
  rgmii_if.phy link,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_err,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output logic tx_out_err
);
  logic fifo_valid;
  logic fifo_ready;
  logic [FIFO_WIDTH-1:0] fifo_data;

  stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data({rx_in_err, rx_in_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // The receive clock is made here, stepped by the speed.
  link_sender u_send (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .speed(speed),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data[7:0]),
    .in_err(fifo_data[8]),
    .lclk(link.rx_clk),
    .ctl(link.rx_ctl),
    .dat(link.rxd)
  );

  link_receiver u_recv (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .speed(speed),
    .lclk(link.tx_clk),
    .ctl(link.tx_ctl),
    .dat(link.txd),
    .out_valid(tx_out_valid),
    .out_data(tx_out_data),
    .out_err(tx_out_err)
  );
endmodule : rgmii_phy_end

//--- src/rgmii_mac_end.sv
// Host controller end: drives the transmit lane and takes the receive lane.
`timescale 1ns/1ps
module rgmii_mac_end
  import rgmii_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input link_speed_e speed,
  rgmii_if.mac link,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_err,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic rx_out_err
);
  logic fifo_valid;
  logic fifo_ready;
  logic [FIFO_WIDTH-1:0] fifo_data;

  stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data({tx_in_err, tx_in_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // The transmit clock is made here at the selected speed.
  link_sender u_send (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .speed(speed),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data[7:0]),
    .in_err(fifo_data[8]),
    .lclk(link.tx_clk),
    .ctl(link.tx_ctl),
    .dat(link.txd)
  );

  link_receiver u_recv (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .speed(speed),
    .lclk(link.rx_clk),
    .ctl(link.rx_ctl),
    .dat(link.rxd),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_err(rx_out_err)
  );
endmodule : rgmii_mac_end

//--- testbench/rgmii_properties.sv
// Concurrent checks on the link pins between the two ends.
`timescale 1ns/1ps
module rgmii_properties
  import rgmii_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire link_speed_e speed,
  input wire logic tx_clk,
  input wire logic tx_ctl,
  input wire logic [3:0] txd,
  input wire logic rx_clk,
  input wire logic rx_ctl,
  input wire logic [3:0] rxd
);
  // ------------------------------------------------------------------
  // Clock phases, sampling margins and idle control
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_tx_half_1000: assert property ($rose(tx_clk) && speed == SPEED_1000 |-> ##4 $fell(tx_clk))
    else $error("tx clock high phase wrong at gigabit");
  a_tx_half_100: assert property ($rose(tx_clk) && speed == SPEED_100 |-> ##20 $fell(tx_clk))
    else $error("tx clock high phase wrong at 100");
  a_rx_half_1000: assert property ($rose(rx_clk) && speed == SPEED_1000 |-> ##4 $fell(rx_clk))
    else $error("rx clock high phase wrong at gigabit");
  a_rx_half_10: assert property ($rose(rx_clk) && speed == SPEED_10 |-> ##200 $fell(rx_clk))
    else $error("rx clock high phase wrong at 10");
  // Pins may only move mid-phase, so the far end always samples a settled value.
  a_tx_edge_stable: assert property ($changed(tx_clk) |-> $stable(txd) && $stable(tx_ctl))
    else $error("tx pins moved at a clock edge");
  a_rx_edge_stable: assert property ($changed(rx_clk) |-> $stable(rxd) && $stable(rx_ctl))
    else $error("rx pins moved at a clock edge");
  a_tx_idle_ctl: assert property ($rose(tx_clk) && !tx_ctl && speed == SPEED_1000 |-> !tx_ctl [*4])
    else $error("tx control rose in an idle cycle");
  a_rx_idle_ctl: assert property ($rose(rx_clk) && !rx_ctl && speed == SPEED_1000 |-> !rx_ctl [*4])
    else $error("rx control rose in an idle cycle");
  a_tx_slow_nibble: assert property ($changed(txd) && speed != SPEED_1000 |-> !tx_clk)
    else $error("tx nibble moved in high phase");
  a_rx_slow_nibble: assert property ($changed(rxd) && speed != SPEED_1000 |-> !rx_clk)
    else $error("rx nibble moved in high phase");

  c_tx_giga_byte: cover property ($rose(tx_clk) && tx_ctl && speed == SPEED_1000);
  c_rx_error_byte: cover property ($rose(rx_clk) && rx_ctl ##4 !rx_ctl);
  c_rx_slow_byte: cover property ($rose(rx_clk) && rx_ctl && speed == SPEED_10);
endmodule : rgmii_properties

//--- testbench/testbench.sv
// Self-checking bench joining the device end and the host end over one link.
`timescale 1ns/1ps
module testbench
  import rgmii_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  link_speed_e speed = SPEED_1000;
  logic [1:0] v = 2'h0;
  logic [1:0] e = 2'h0;
  logic [7:0] d [2] = '{default: 8'h00};
  wire [1:0] rdy;
  wire [1:0] ov;
  wire [1:0] oe;
  wire [7:0] od [2];
  logic [8:0] q [2][$];
  int failures = 0;
  int num_checks = 0;

  rgmii_if link ();
  rgmii_mac_end i_rgmii_mac_end (.ref_clk(ref_clk), .resetn(resetn), .speed(speed),
    .link(link), .tx_in_valid(v[0]), .tx_in_ready(rdy[0]), .tx_in_data(d[0]),
    .tx_in_err(e[0]), .rx_out_valid(ov[1]), .rx_out_data(od[1]), .rx_out_err(oe[1]));
  rgmii_phy_end i_rgmii_phy_end (.ref_clk(ref_clk), .resetn(resetn), .speed(speed),
    .link(link), .rx_in_valid(v[1]), .rx_in_ready(rdy[1]), .rx_in_data(d[1]),
    .rx_in_err(e[1]), .tx_out_valid(ov[0]), .tx_out_data(od[0]), .tx_out_err(oe[0]));
  rgmii_properties i_rgmii_properties (.ref_clk(ref_clk), .resetn(resetn), .speed(speed),
    .tx_clk(link.tx_clk), .tx_ctl(link.tx_ctl), .txd(link.txd),
    .rx_clk(link.rx_clk), .rx_ctl(link.rx_ctl), .rxd(link.rxd));

  always #50 ref_clk = ~ref_clk;

  // Index 0 is the host-to-device path, index 1 the device-to-host path.
  always @(negedge ref_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (ov[k] === 1'b1) begin
        q[k].push_back({oe[k], od[k]});
      end
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [8:0] word(input int i);
    return {i % 5 == 0, 8'(i * 37 + 90)};
  endfunction : word

  task automatic tally_and_finish(input bit hung);
    if (hung) begin
      failures++;
      $display("ERROR at %0t: wait ran out", $time);
    end
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input link_speed_e s);
    @(negedge ref_clk);
    resetn = 1'b0;
    speed = s;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    q[0].delete();
    q[1].delete();
  endtask : do_reset

  task automatic push(input int k, input int n, output bit full);
    int t;
    full = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      {e[k], d[k]} = word(i);
      v[k] = 1'b1;
      t = 0;
      while (rdy[k] !== 1'b1 && t < 5000) begin
        full = 1'b1;
        t++;
        @(negedge ref_clk);
      end
      if (t >= 5000) tally_and_finish(1'b1);
    end
    @(negedge ref_clk);
    v[k] = 1'b0;
  endtask : push

  task automatic clk_period(input bit rx, input int want);
    int n = 0;
    int r = 0;
    int t = 0;
    logic p = 1'b1;
    logic c;
    while (r < 2 && t < 1000) begin
      @(negedge ref_clk);
      c = rx ? link.rx_clk : link.tx_clk;
      if (c === 1'b1 && p === 1'b0) r++;
      if (r == 1) n++;
      p = c;
      t++;
    end
    if (r < 2) tally_and_finish(1'b1);
    num_checks++;
    if (n != want) begin
      failures++;
      $display("ERROR at %0t: link clock period", $time);
    end
  endtask : clk_period

  task automatic wire_first_byte();
    logic [8:0] w = word(0);
    logic [3:0] lo;
    int t = 0;
    while (!(link.rx_clk === 1'b1 && link.rx_ctl === 1'b1) && t < 300) begin
      t++;
      @(negedge ref_clk);
    end
    lo = link.rxd;
    while (link.rx_clk !== 1'b0 && t < 300) begin
      t++;
      @(negedge ref_clk);
    end
    if (t >= 300) tally_and_finish(1'b1);
    num_checks++;
    if ({link.rxd, lo} !== w[7:0]) begin
      failures++;
      $display("ERROR at %0t: rx nibble order", $time);
    end
    num_checks++;
    if (link.rx_ctl !== ~w[8]) begin
      failures++;
      $display("ERROR at %0t: rx falling control", $time);
    end
  endtask : wire_first_byte

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic run_idle();
    logic busy = 1'b0;
    do_reset(SPEED_1000);
    repeat (200) begin
      @(negedge ref_clk);
      busy = busy | link.tx_ctl | link.rx_ctl | (|link.rxd) | (|link.txd);
    end
    num_checks++;
    if (busy !== 1'b0 || q[0].size() != 0 || q[1].size() != 0) begin
      failures++;
      $display("ERROR at %0t: idle link busy", $time);
    end
  endtask : run_idle

  // Twenty-four words overrun the 16-word buffer at every speed, so both
  // senders are refused for a while and then drained to empty.
  task automatic run_stream(input link_speed_e s, input int want);
    bit f0;
    bit f1;
    int t = 0;
    do_reset(s);
    fork
      push(0, 24, f0);
      push(1, 24, f1);
      clk_period(1'b0, want);
      clk_period(1'b1, want);
      if (s == SPEED_1000) wire_first_byte();
    join
    num_checks++;
    if (!(f0 && f1)) begin
      failures++;
      $display("ERROR at %0t: buffer never refused", $time);
    end
    while ((q[0].size() < 24 || q[1].size() < 24) && t < 40000) begin
      t++;
      @(negedge ref_clk);
    end
    if (t >= 40000) tally_and_finish(1'b1);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 24; i++) begin
        num_checks++;
        if (q[k][i] !== word(i)) begin
          failures++;
          $display("ERROR at %0t: byte or error flag wrong", $time);
        end
      end
    end
  endtask : run_stream

  initial begin
    run_idle();
    run_stream(SPEED_1000, LINK_PERIOD_1000_NS / REF_PERIOD_NS);
    run_stream(SPEED_100, LINK_PERIOD_100_NS / REF_PERIOD_NS);
    run_stream(SPEED_10, LINK_PERIOD_10_NS / REF_PERIOD_NS);
    tally_and_finish(1'b0);
  end
endmodule : testbench
